// ==== include/simap_buf_if.sv ====
// Handshake bundle between the register front end and the frame buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface simap_buf_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] in_data;
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] out_data;
    logic             out_valid;
    logic             out_ready;
    modport store (input in_data, input in_valid, output in_ready,
                   output out_data, output out_valid, input out_ready);
    modport user  (output in_data, output in_valid, input in_ready,
                   input out_data, input out_valid, output out_ready);
endinterface

// ==== include/simap_pkg.sv ====
// Constants and types for the two-wire address-frame channel.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register port.
package simap_pkg;
    localparam int CLK_HZ      = 125_000_000;
    localparam int STD_RATE_HZ = 100_000;
    localparam int HALF_CYCLES = CLK_HZ / (2 * STD_RATE_HZ);

    // Register byte offsets
    localparam logic [4:0] OFF_LEVELS  = 5'h00;
    localparam logic [4:0] OFF_ENABLES = 5'h04;
    localparam logic [4:0] OFF_DATA    = 5'h08;
    localparam logic [4:0] OFF_CTRL    = 5'h0C;
    localparam logic [4:0] OFF_DIV     = 5'h10;
    localparam logic [4:0] OFF_STATUS  = 5'h14;

    // Field positions
    localparam int BIT_DATA_OUT  = 2;
    localparam int BIT_CLOCK_OUT = 10;
    localparam int BIT_OUT_EN    = 2;
    localparam int CTRL_UNIT_EN  = 0;
    localparam int CTRL_CH_START = 1;
    localparam int CTRL_IRQ_MODE = 2;
    localparam int ST_BUSY       = 0;
    localparam int ST_ACK_ERR    = 1;
    localparam int ST_BUF_FULL   = 2;

    // Reset values
    localparam logic [15:0] RST_LEVELS  = 16'h0F0F;
    localparam logic [15:0] RST_ENABLES = 16'h0000;
    localparam logic [15:0] RST_DIV     = 16'(HALF_CYCLES);
    localparam logic [2:0]  RST_CTRL    = 3'h0;

    // Timing and framing
    localparam logic [15:0] MIN_HALF   = 16'h0002;
    localparam logic [3:0]  ACK_INDEX  = 4'h8;
    localparam int          FRAME_BITS = 8;

    typedef enum {ST_IDLE, ST_LOW, ST_HIGH} simap_state_t;
endpackage

// ==== src/simap_buffer.sv ====
// Small valid/ready buffer holding address bytes waiting for the shifter.
// Assumes asynchronous active-low reset already released in the clk domain.
`timescale 1ns/1ns
module simap_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic    clk,
    input  wire logic    rst_n,
    simap_buf_if.store   port
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    assign port.in_ready  = (count != (PW+1)'(DEPTH));
    assign port.out_valid = (count != '0);
    assign port.out_data  = mem[rd_ptr];
    assign push = port.in_valid & port.in_ready;
    assign pop  = port.out_valid & port.out_ready;

    always_comb begin
        next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = (PW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (PW+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= port.in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end
endmodule

// ==== src/simap_channel.sv ====
// Two-wire master channel sending the address frame, with Avalon-MM registers.
// Assumes open-drain pads outside; pins pulled high when no one drives them.
//
// Notes on behaviour
// - Address frame always goes first in transactions
// - After start, send address plus direction
// - Eight bits, MSB first, bit zero direction
// - Only transfer-end interrupt; buffer-empty mode forbidden
// - Missing acknowledge reported on ack error flag
// - Data non-inverted, data line idles high
// - Ninth clock samples slave acknowledge, no parity
// - Sole master: no arbitration, no stretch detection
// - Ack error means data high during ack
`timescale 1ns/1ns
module simap_channel (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             two_wire_clock_pin_o,
    output logic             two_wire_clock_pin_oe,
    input  wire logic        two_wire_data_pin_i,
    output logic             two_wire_data_pin_o,
    output logic             two_wire_data_pin_oe,
    output logic             two_wire_done_irq
);
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Data pin input: three stages, level accepted when the last two agree
    logic sda_m;
    logic sda_s2;
    logic sda_s3;
    logic sda_level;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_m     <= 1'b1;
            sda_s2    <= 1'b1;
            sda_s3    <= 1'b1;
            sda_level <= 1'b1;
        end else begin
            sda_m  <= two_wire_data_pin_i;
            sda_s2 <= sda_m;
            sda_s3 <= sda_s2;
            if (sda_s2 == sda_s3) begin
                sda_level <= sda_s3;
            end
        end
    end

    simap_buf_if #(.WIDTH(8)) bq ();

    simap_buffer #(.WIDTH(8), .DEPTH(2)) u_buffer (
        .clk   (clk),
        .rst_n (rst_n),
        .port  (bq)
    );

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Register and shifter state
    logic [15:0]         serial_output_levels;
    logic [15:0]         serial_output_enables;
    logic [2:0]          channel_mode_reg;
    logic [15:0]         channel_clock_div;
    logic                ack_error_flag;
    logic [7:0]          shift_byte_buffer;
    logic [7:0]          rx_byte;
    logic [3:0]          bit_idx;
    logic [15:0]         phase_cnt;
    simap_pkg::simap_state_t state;
    logic                rd_ack;
    logic [31:0]         next_readdata;
    logic                next_irq;

    logic [15:0]         next_levels;
    logic [15:0]         next_enables;
    logic [2:0]          next_mode;
    logic [15:0]         next_div;
    logic                next_ack_error;
    logic [7:0]          next_shift;
    logic [7:0]          next_rx;
    logic [3:0]          next_bit_idx;
    logic [15:0]         next_phase_cnt;
    simap_pkg::simap_state_t next_state;
    logic                next_rd_ack;

    logic                data_hit;
    logic                wr_go;
    logic                rd_first;
    logic                transfer_status_flag;
    logic [15:0]         half_len;
    logic                phase_end;
    logic                can_start;
    logic                shift_sda;
    logic                shift_scl;
    logic                pin_sda;
    logic                pin_scl;
    // Data level one cycle behind the pin logic
    logic                sda_hold;

    assign data_hit  = (avs_address == simap_pkg::OFF_DATA);
    // Reads answer in their second cycle since readdata is registered;
    // a data write waits while both buffer slots are taken
    assign avs_waitrequest = (avs_read & ~rd_ack) | (avs_write & data_hit & ~bq.in_ready);
    assign wr_go     = avs_write & ~avs_waitrequest;
    assign rd_first  = avs_read & ~rd_ack;
    assign bq.in_valid = avs_write & data_hit;
    assign bq.in_data  = avs_writedata[7:0];

    assign transfer_status_flag = (state != simap_pkg::ST_IDLE);
    assign half_len  = (channel_clock_div < simap_pkg::MIN_HALF) ? simap_pkg::MIN_HALF : channel_clock_div;
    assign phase_end = (phase_cnt == 16'(half_len - 16'h0001));
    // A frame starts only once software has set the unit enable and channel start bits and enabled the output
    assign can_start = channel_mode_reg[simap_pkg::CTRL_UNIT_EN] & channel_mode_reg[simap_pkg::CTRL_CH_START]
                     & serial_output_enables[simap_pkg::BIT_OUT_EN];
    assign bq.out_ready = (state == simap_pkg::ST_IDLE) & can_start;

    // Shifter: clock low while data changes, high while it is stable
    always_comb begin
        shift_scl = (state == simap_pkg::ST_HIGH);
        shift_sda = (bit_idx == simap_pkg::ACK_INDEX) ? 1'b1 : shift_byte_buffer[7];
    end

    // While idle the pins follow the software output bits
    always_comb begin
        if (transfer_status_flag) begin
            pin_scl = shift_scl;
            pin_sda = shift_sda;
        end else begin
            pin_scl = serial_output_levels[simap_pkg::BIT_CLOCK_OUT];
            pin_sda = serial_output_levels[simap_pkg::BIT_DATA_OUT];
        end
    end

    always_comb begin
        next_levels    = serial_output_levels;
        next_enables   = serial_output_enables;
        next_mode      = channel_mode_reg;
        next_div       = channel_clock_div;
        next_ack_error = ack_error_flag;
        next_shift     = shift_byte_buffer;
        next_rx        = rx_byte;
        next_bit_idx   = bit_idx;
        next_phase_cnt = phase_cnt;
        next_state     = state;
        next_irq       = 1'b0;
        next_rd_ack    = rd_first;
        next_readdata  = avs_readdata;

        if (wr_go) begin
            case (avs_address)
                simap_pkg::OFF_LEVELS: begin
                    next_levels = merge16(serial_output_levels, avs_writedata, avs_byteenable);
                end
                simap_pkg::OFF_ENABLES: begin
                    next_enables = merge16(serial_output_enables, avs_writedata, avs_byteenable);
                end
                simap_pkg::OFF_CTRL: begin
                    if (avs_byteenable[0]) begin
                        next_mode = avs_writedata[2:0];
                        next_mode[simap_pkg::CTRL_IRQ_MODE] = 1'b0;
                    end
                end
                simap_pkg::OFF_DIV: begin
                    next_div = merge16(channel_clock_div, avs_writedata, avs_byteenable);
                end
                simap_pkg::OFF_STATUS: begin
                    if (avs_byteenable[0] && avs_writedata[simap_pkg::ST_ACK_ERR]) begin
                        next_ack_error = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // No clock-stretch or arbitration check: the clock pin is never read back
        case (state)
            simap_pkg::ST_IDLE: begin
                if (bq.out_valid && can_start) begin
                    next_shift     = bq.out_data;
                    next_bit_idx   = 4'h0;
                    next_phase_cnt = 16'h0000;
                    next_state     = simap_pkg::ST_LOW;
                end
            end
            simap_pkg::ST_LOW: begin
                next_phase_cnt = 16'(phase_cnt + 16'h0001);
                if (phase_end) begin
                    next_phase_cnt = 16'h0000;
                    next_state     = simap_pkg::ST_HIGH;
                end
            end
            simap_pkg::ST_HIGH: begin
                next_phase_cnt = 16'(phase_cnt + 16'h0001);
                if (phase_end) begin
                    next_phase_cnt = 16'h0000;
                    if (bit_idx == simap_pkg::ACK_INDEX) begin
                        if (sda_level) begin
                            next_ack_error = 1'b1;
                        end
                        next_irq   = 1'b1;
                        next_state = simap_pkg::ST_IDLE;
                        // Park the clock low and data released so disabling output is glitch-free
                        next_levels[simap_pkg::BIT_CLOCK_OUT] = 1'b0;
                        next_levels[simap_pkg::BIT_DATA_OUT]  = 1'b1;
                    end else begin
                        next_rx      = {rx_byte[6:0], sda_level};
                        next_shift   = {shift_byte_buffer[6:0], 1'b0};
                        next_bit_idx = 4'(bit_idx + 4'h1);
                        next_state   = simap_pkg::ST_LOW;
                    end
                end
            end
            default: begin
                next_state = simap_pkg::ST_IDLE;
            end
        endcase

        if (rd_first) begin
            case (avs_address)
                simap_pkg::OFF_LEVELS:  next_readdata = {16'h0000, serial_output_levels};
                simap_pkg::OFF_ENABLES: next_readdata = {16'h0000, serial_output_enables};
                simap_pkg::OFF_DATA:    next_readdata = {24'h000000, rx_byte};
                simap_pkg::OFF_CTRL:    next_readdata = {29'h00000000, channel_mode_reg};
                simap_pkg::OFF_DIV:     next_readdata = {16'h0000, channel_clock_div};
                simap_pkg::OFF_STATUS:  next_readdata = {29'h00000000, ~bq.in_ready,
                                                         ack_error_flag, transfer_status_flag};
                default:                next_readdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_output_levels  <= simap_pkg::RST_LEVELS;
            serial_output_enables <= simap_pkg::RST_ENABLES;
            channel_mode_reg      <= simap_pkg::RST_CTRL;
            channel_clock_div     <= simap_pkg::RST_DIV;
            ack_error_flag        <= 1'b0;
            shift_byte_buffer     <= 8'h00;
            rx_byte               <= 8'h00;
            bit_idx               <= 4'h0;
            phase_cnt             <= 16'h0000;
            state                 <= simap_pkg::ST_IDLE;
            rd_ack                <= 1'b0;
            avs_readdata          <= 32'h00000000;
            two_wire_done_irq     <= 1'b0;
            two_wire_clock_pin_oe <= 1'b0;
            two_wire_data_pin_oe  <= 1'b0;
            sda_hold              <= 1'b1;
        end else begin
            serial_output_levels  <= next_levels;
            serial_output_enables <= next_enables;
            channel_mode_reg      <= next_mode;
            channel_clock_div     <= next_div;
            ack_error_flag        <= next_ack_error;
            shift_byte_buffer     <= next_shift;
            rx_byte               <= next_rx;
            bit_idx               <= next_bit_idx;
            phase_cnt             <= next_phase_cnt;
            state                 <= next_state;
            rd_ack                <= next_rd_ack;
            avs_readdata          <= next_readdata;
            two_wire_done_irq     <= next_irq;
            // Open drain: enable pulls the wire low
            two_wire_clock_pin_oe <= ~pin_scl;
            // Data trails the clock by one cycle, so it never moves while
            // the clock is still falling; the half period must stay at two or more
            sda_hold              <= pin_sda;
            two_wire_data_pin_oe  <= ~sda_hold;
        end
    end

    assign two_wire_clock_pin_o = 1'b0;
    assign two_wire_data_pin_o  = 1'b0;
endmodule

// ==== testbench/simap_channel_tb_top.sv ====
// Self-checking bench: register accesses over Avalon-MM and address frames to a slave.
// Assumes the checker is bound separately and the slave model answers address 0x52.
`timescale 1ns/1ns
`define check_eq(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module simap_channel_tb_top;
    localparam logic [6:0] SLAVE_ADDR = 7'h52;
    logic        clk = 1'b0;
    logic        arst_n;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        scl_o, scl_oe, sda_o, sda_oe, irq, sda_pull;
    wire         scl_w;
    wire         sda_w;
    logic [7:0]  slv_byte;
    int          slv_frames;
    logic [31:0] rd_data;
    logic [7:0]  addr_bytes [4] = '{8'hA4, 8'h5B, 8'hA5, 8'h24};
    logic        wait_seen;
    logic [31:0] rdata_seen;
    int          n_irq = 0;
    int          n_errors;
    int          checks_done;

    // Open-drain wires with pull-ups
    assign scl_w = scl_oe ? scl_o : 1'b1;
    assign sda_w = (sda_oe ? sda_o : 1'b1) & ~sda_pull;

    simap_channel dut_u (
        .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .two_wire_clock_pin_o(scl_o), .two_wire_clock_pin_oe(scl_oe),
        .two_wire_data_pin_i(sda_w), .two_wire_data_pin_o(sda_o), .two_wire_data_pin_oe(sda_oe),
        .two_wire_done_irq(irq)
    );

    simap_slave_model #(.SLAVE_ADDR(SLAVE_ADDR)) slave_u (
        .scl(scl_w), .sda(sda_w), .sda_pull(sda_pull), .last_byte(slv_byte), .frames(slv_frames)
    );

    always #4 clk = ~clk;

    // Answer and done pulses as they stand at the coming rising edge
    always @(negedge clk) begin
        wait_seen <= avs_waitrequest;
        rdata_seen <= avs_readdata;
        if (irq === 1'b1) n_irq <= n_irq + 1;
    end

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wait_frames(input int want);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk);
            if (n_irq >= want) break;
        end
        if (i == 3000) begin
            n_errors++;
            report_and_stop();
        end
    endtask

    // Request held from a rising edge until the edge that sees waitrequest low
    task automatic bus_op(input logic is_read, input logic [4:0] addr, input logic [31:0] data);
        int i;
        @(posedge clk);
        avs_address <= addr;
        avs_writedata <= data;
        avs_read <= is_read;
        avs_write <= !is_read;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk);
            if (wait_seen === 1'b0) break;
        end
        rd_data = rdata_seen;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 3000) begin
            n_errors++;
            report_and_stop();
        end
    endtask

    initial begin
        arst_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        n_errors = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        bus_op(1'b1, simap_pkg::OFF_LEVELS, 32'h0);
        `check_eq(rd_data[15:0], simap_pkg::RST_LEVELS)
        bus_op(1'b1, simap_pkg::OFF_ENABLES, 32'h0);
        `check_eq(rd_data[15:0], simap_pkg::RST_ENABLES)
        bus_op(1'b1, simap_pkg::OFF_DIV, 32'h0);
        `check_eq(rd_data[15:0], simap_pkg::RST_DIV)
        bus_op(1'b0, 5'h18, 32'hFFFF_FFFF);
        bus_op(1'b1, 5'h18, 32'h0);
        `check_eq(rd_data, 32'h0000_0000)
        `check_eq({scl_w, sda_w}, 2'b11)
        bus_op(1'b0, simap_pkg::OFF_CTRL, 32'h0000_0005);
        repeat (4) @(posedge clk);
        bus_op(1'b1, simap_pkg::OFF_CTRL, 32'h0);
        `check_eq(rd_data[2:0], 3'h1)
        // Four-cycle halves give a 64 ns wire clock, an eighth of the system clock
        bus_op(1'b0, simap_pkg::OFF_DIV, 32'h0000_0004);
        bus_op(1'b0, simap_pkg::OFF_LEVELS, 32'h0000_0F0B);
        repeat (3) @(posedge clk);
        `check_eq({scl_w, sda_w}, 2'b10)
        bus_op(1'b0, simap_pkg::OFF_LEVELS, 32'h0000_0B0B);
        repeat (3) @(posedge clk);
        `check_eq({scl_w, sda_w}, 2'b00)
        bus_op(1'b0, simap_pkg::OFF_ENABLES, 32'h0000_0004);
        bus_op(1'b0, simap_pkg::OFF_DATA, {24'h0, addr_bytes[0]});
        bus_op(1'b0, simap_pkg::OFF_DATA, {24'h0, addr_bytes[1]});
        bus_op(1'b1, simap_pkg::OFF_STATUS, 32'h0);
        `check_eq(rd_data[2:0], 3'h4)
        bus_op(1'b0, simap_pkg::OFF_CTRL, 32'h0000_0003);
        bus_op(1'b1, simap_pkg::OFF_STATUS, 32'h0);
        `check_eq(rd_data[simap_pkg::ST_BUSY], 1'b1)
        bus_op(1'b0, simap_pkg::OFF_DATA, {24'h0, addr_bytes[2]});
        // Buffer is full here, so this write stalls until the second frame takes a byte
        bus_op(1'b0, simap_pkg::OFF_DATA, {24'h0, addr_bytes[3]});
        for (int k = 0; k < 4; k++) begin
            wait_frames(k + 1);
            repeat (4) @(posedge clk);
            `check_eq(slv_byte, addr_bytes[k])
            `check_eq(slv_frames, k + 1)
            bus_op(1'b1, simap_pkg::OFF_STATUS, 32'h0);
            `check_eq(rd_data[simap_pkg::ST_ACK_ERR], addr_bytes[k][7:1] != SLAVE_ADDR)
            bus_op(1'b0, simap_pkg::OFF_STATUS, 32'h0000_0002);
        end
        repeat (20) @(posedge clk);
        bus_op(1'b1, simap_pkg::OFF_STATUS, 32'h0);
        `check_eq(rd_data[2:0], 3'h0)
        `check_eq(sda_w, 1'b1)
        report_and_stop();
    end
endmodule

// ==== testbench/simap_checker.sv ====
// Port-level assertions for the two-wire address-frame channel.
// Assumes it is bound to the channel's top module and sees only its ports.
`timescale 1ns/1ns
module simap_channel_checker (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        two_wire_clock_pin_oe,
    input wire logic        two_wire_data_pin_oe,
    input wire logic        two_wire_done_irq
);
    logic [15:0] lvl_q;
    logic [15:0] next_lvl_q;
    logic        out_en_q;
    logic        next_out_en_q;
    logic        scl_oe_q;
    logic [3:0]  rises_q;
    logic [3:0]  next_rises_q;
    logic        wr_ok;

    assign wr_ok = avs_write && !avs_waitrequest;

    // Shadow of the level and enable bits; only trusted while the enable is off
    always_comb begin
        next_lvl_q = lvl_q;
        next_out_en_q = out_en_q;
        next_rises_q = rises_q;
        if (wr_ok && avs_address == simap_pkg::OFF_LEVELS) begin
            if (avs_byteenable[0]) next_lvl_q[7:0] = avs_writedata[7:0];
            if (avs_byteenable[1]) next_lvl_q[15:8] = avs_writedata[15:8];
        end
        if (wr_ok && avs_address == simap_pkg::OFF_ENABLES && avs_byteenable[0])
            next_out_en_q = avs_writedata[simap_pkg::BIT_OUT_EN];
        if (two_wire_done_irq)
            next_rises_q = 4'h0;
        else if (out_en_q && scl_oe_q && !two_wire_clock_pin_oe)
            next_rises_q = rises_q + 4'h1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lvl_q    <= simap_pkg::RST_LEVELS;
            out_en_q <= 1'b0;
            scl_oe_q <= 1'b0;
            rises_q  <= 4'h0;
        end else begin
            lvl_q    <= next_lvl_q;
            out_en_q <= next_out_en_q;
            scl_oe_q <= two_wire_clock_pin_oe;
            rises_q  <= next_rises_q;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read answer not on second cycle");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > simap_pkg::OFF_STATUS
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    irq_mode_a: assert property (avs_read && !avs_waitrequest && avs_address == simap_pkg::OFF_CTRL
        |-> !avs_readdata[simap_pkg::CTRL_IRQ_MODE]) else $error("buffer-empty mode reads set");
    irq_pulse_a: assert property (two_wire_done_irq |=> !two_wire_done_irq)
        else $error("done pulse longer than one cycle");
    nine_clocks_a: assert property (two_wire_done_irq |-> rises_q == 4'h9)
        else $error("frame did not have nine clocks");
    ack_release_a: assert property (rises_q == 4'h8 && two_wire_clock_pin_oe && $past(two_wire_clock_pin_oe)
        && $past(two_wire_clock_pin_oe, 2) |-> !two_wire_data_pin_oe) else $error("data held during ack clock");
    sw_data_a: assert property (!out_en_q && $stable(lvl_q) && $past(lvl_q) == $past(lvl_q, 2)
        |-> two_wire_data_pin_oe == !lvl_q[simap_pkg::BIT_DATA_OUT]) else $error("data pin ignores level bit");
    sw_clock_a: assert property (!out_en_q && $stable(lvl_q) && $past(lvl_q) == $past(lvl_q, 2)
        |-> two_wire_clock_pin_oe == !lvl_q[simap_pkg::BIT_CLOCK_OUT]) else $error("clock pin ignores level bit");
    frame_data_a: assert property (out_en_q && $changed(two_wire_data_pin_oe)
        |-> two_wire_clock_pin_oe && $past(two_wire_clock_pin_oe)) else $error("data moved while clock high");

    cover property (two_wire_done_irq);
    cover property ($rose(avs_read));
    cover property (avs_write && avs_waitrequest);
endmodule

bind simap_channel simap_channel_checker checker_u (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .two_wire_clock_pin_oe(two_wire_clock_pin_oe),
    .two_wire_data_pin_oe(two_wire_data_pin_oe), .two_wire_done_irq(two_wire_done_irq)
);

// ==== testbench/simap_slave_model.sv ====
// Behavioural two-wire slave that acknowledges one seven-bit address.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ns
module simap_slave_model #(
    parameter logic [6:0] SLAVE_ADDR = 7'h52
) (
    input  wire logic  scl,
    input  wire logic  sda,
    output logic       sda_pull,
    output logic [7:0] last_byte,
    output int         frames
);
    logic [7:0] shreg = 8'h00;
    int         nbits = 0;
    logic       pull_q = 1'b0;
    logic [7:0] byte_q = 8'h00;
    int         count_q = 0;

    assign sda_pull  = pull_q;
    assign last_byte = byte_q;
    assign frames    = count_q;

    // Start condition restarts the bit count
    always @(negedge sda) begin
        if (scl) nbits <= 0;
    end

    always @(posedge scl) begin
        nbits <= nbits + 1;
        if (nbits < 8) shreg <= {shreg[6:0], sda};
    end

    // No repeated start between buffered bytes, so the count wraps after the ack
    always @(negedge scl) begin
        if (nbits == 8) pull_q <= (shreg[7:1] == SLAVE_ADDR);
        if (nbits == 9) begin
            pull_q <= 1'b0;
            byte_q <= shreg;
            count_q <= count_q + 1;
            nbits <= 0;
        end
    end
endmodule
